// ### inc/ctai_pkg.sv
// Purpose: Shared constants and types for the transfer/add instruction core.
// Assumes: 10-bit instruction words, 4-bit data path, single clock.
// Notes: Function list below gives each operation the core carries out.
// Function
// - Bank pointer to accumulator copies two bank bits into accumulator low bits.
// - File pointer to accumulator copies all four bits, pointer kept.
// - Stack pointer to accumulator fills the three low accumulator bits.
// - Pointer pair load sets file and digit pointers; consecutive repeats skipped.
// - Bank pointer load writes its immediate into the bank pointer.
// - Digit pointer increment; skip next when result wraps to zero.
// - Digit pointer decrement; skip next when result becomes fifteen.
// - Memory to accumulator, then file pointer XOR immediate j.
// - Memory exchange swaps nibble and accumulator, file pointer XOR j.
// - Exchange then decrement digit pointer, skip when it becomes fifteen.
// - Exchange then increment digit pointer, skip when it becomes zero.
// - Accumulator to memory, then file pointer XOR immediate j.
// - Immediate accumulator load of a 4-bit value in one cycle.
// - Table reference pushes counter, fetches ROM word into upper and accumulator, pops.
// - Plain memory add without carry into accumulator, one cycle.
// - Add with carry stores 4-bit sum and carry out.
// - Consecutive immediate accumulator loads: only the first executes.
package ctai_pkg;
    localparam int CTAI_IW = 10;
    localparam int CTAI_DW = 4;
    // Opcode matching: fixed words and prefix patterns.
    localparam logic [9:0] CTAI_OP_BANK_TO_ACC = 10'h029;
    localparam logic [9:0] CTAI_OP_FILE_TO_ACC = 10'h052;
    localparam logic [9:0] CTAI_OP_STACK_TO_ACC = 10'h05;
    localparam logic [9:0] CTAI_OP_INC_DIGIT = 10'h013;
    localparam logic [9:0] CTAI_OP_DEC_DIGIT = 10'h017;
    localparam logic [9:0] CTAI_OP_MEM_ADD = 10'h00a;
    localparam logic [9:0] CTAI_OP_MEM_ADDC = 10'h00b;
    localparam logic [1:0] CTAI_PFX_PAIR = 2'h3;
    localparam logic [7:0] CTAI_PFX_BANK = 8'h12;
    localparam logic [5:0] CTAI_PFX_LDA = 6'h07;
    localparam logic [5:0] CTAI_PFX_M2A = 6'h2c;
    localparam logic [5:0] CTAI_PFX_XCH = 6'h2d;
    localparam logic [5:0] CTAI_PFX_XCHD = 6'h2f;
    localparam logic [5:0] CTAI_PFX_XCHI = 6'h2e;
    localparam logic [5:0] CTAI_PFX_A2M = 6'h2b;
    localparam logic [4:0] CTAI_PFX_TAB = 5'h04;
    localparam logic [3:0] CTAI_DIGIT_WRAP_UP = 4'h0;
    localparam logic [3:0] CTAI_DIGIT_WRAP_DN = 4'hf;

    typedef enum logic [3:0] {
        CTAI_K_NONE, CTAI_K_BANK_A, CTAI_K_FILE_A, CTAI_K_STACK_A,
        CTAI_K_PAIR, CTAI_K_BANK_LD, CTAI_K_INC, CTAI_K_DEC,
        CTAI_K_M2A, CTAI_K_XCH, CTAI_K_XCHD, CTAI_K_XCHI,
        CTAI_K_A2M, CTAI_K_LDA, CTAI_K_TAB, CTAI_K_ADD
    } ctai_kind_e;

    typedef struct packed {
        logic [1:0] bank;
        logic [3:0] file;
        logic [3:0] digit;
    } ctai_dptr_s;
endpackage

// ### hw/ctai_decode.sv
// Purpose: Classifies one instruction word into an operation kind.
// Assumes: Purely combinational; called once per fetch.
// Notes: Unlisted words decode to none and leave the core idle.
`timescale 1ns/1ps
module ctai_decode
    import ctai_pkg::*;
(
    input wire logic [9:0] word,
    output ctai_kind_e kind,
    output logic with_carry
);
    always_comb begin
        kind = CTAI_K_NONE;
        with_carry = 1'b0;
        if (word == CTAI_OP_BANK_TO_ACC) begin
            kind = CTAI_K_BANK_A;
        end else if (word == CTAI_OP_FILE_TO_ACC) begin
            kind = CTAI_K_FILE_A;
        end else if (word == CTAI_OP_STACK_TO_ACC) begin
            kind = CTAI_K_STACK_A;
        end else if (word == CTAI_OP_INC_DIGIT) begin
            kind = CTAI_K_INC;
        end else if (word == CTAI_OP_DEC_DIGIT) begin
            kind = CTAI_K_DEC;
        end else if (word == CTAI_OP_MEM_ADD) begin
            kind = CTAI_K_ADD;
        end else if (word == CTAI_OP_MEM_ADDC) begin
            kind = CTAI_K_ADD;
            with_carry = 1'b1;
        end else if (word[9:8] == CTAI_PFX_PAIR) begin
            kind = CTAI_K_PAIR;
        end else if (word[9:2] == CTAI_PFX_BANK) begin
            kind = CTAI_K_BANK_LD;
        end else if (word[9:4] == CTAI_PFX_LDA) begin
            kind = CTAI_K_LDA;
        end else if (word[9:4] == CTAI_PFX_M2A) begin
            kind = CTAI_K_M2A;
        end else if (word[9:4] == CTAI_PFX_XCH) begin
            kind = CTAI_K_XCH;
        end else if (word[9:4] == CTAI_PFX_XCHD) begin
            kind = CTAI_K_XCHD;
        end else if (word[9:4] == CTAI_PFX_XCHI) begin
            kind = CTAI_K_XCHI;
        end else if (word[9:4] == CTAI_PFX_A2M) begin
            kind = CTAI_K_A2M;
        end else if (word[9:5] == CTAI_PFX_TAB) begin
            kind = CTAI_K_TAB;
        end
    end
endmodule

// ### hw/ctai_core.sv
// Purpose: Executes transfer, pointer, table and add instructions.
// Assumes: One instruction word offered per cycle with instr_valid; RAM
//          and ROM answer combinationally on the same cycle.
// Notes: Table reference takes two cycles and holds instr_ready low.
`timescale 1ns/1ps
module ctai_core
    import ctai_pkg::*;
#(
    parameter int PAGE_BITS = 5,
    parameter int STACK_BITS = 3
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [6:0] pc_in,
    input wire logic [2:0] table_high_bits,
    output logic instr_ready,
    output logic [3:0] acc_r,
    output logic [3:0] upper_r,
    output logic carry_flag_r,
    output ctai_dptr_s data_pointer_r,
    output logic [STACK_BITS-1:0] stack_pointer_r,
    output logic [PAGE_BITS+6:0] return_stack_r,
    output logic skip_r,
    output logic [7:0] ram_addr,
    input wire logic [3:0] ram_rdata,
    output logic ram_we,
    output logic [3:0] ram_wdata,
    output logic [PAGE_BITS+6:0] rom_addr,
    input wire logic [9:0] rom_rdata,
    output logic pc_load,
    output logic [PAGE_BITS+6:0] pc_load_value
);
    initial begin
        if (PAGE_BITS < 1 || PAGE_BITS > 5 || STACK_BITS != 3) begin
            $error("ctai_core: unsupported parameters");
        end
    end

    // ==========================================================
    // Decode and execution control
    ctai_kind_e kind;
    logic with_carry;
    logic exec;
    logic tab_phase_r;
    logic [PAGE_BITS+6:0] tab_addr_r;
    ctai_kind_e last_kind_r;
    logic load_chain_r;
    logic skip_now;
    logic [3:0] digit_up;
    logic [3:0] digit_dn;
    logic [4:0] sum;

    ctai_decode u_dec (
        .word(instr_word),
        .kind(kind),
        .with_carry(with_carry)
    );

    // A load chain only swallows further loads of the same kind; any other
    // word after a load runs normally even though skip_r is still high.
    assign skip_now = skip_r && (!load_chain_r || kind == last_kind_r);
    // A skipped word still consumes its fetch slot but changes only the skip state.
    assign exec = instr_valid && !skip_now && !tab_phase_r;
    assign instr_ready = !tab_phase_r;
    assign digit_up = data_pointer_r.digit + 4'h1;
    assign digit_dn = data_pointer_r.digit - 4'h1;
    assign sum = {1'b0, acc_r} + {1'b0, ram_rdata}
        + {4'h0, with_carry & carry_flag_r};
    assign ram_addr = {2'h0, data_pointer_r.file, 2'h0} ^
        {data_pointer_r.bank, 2'h0, data_pointer_r.digit};
    assign rom_addr = tab_addr_r;

    // ==========================================================
    // Skip flag: set by skipping ops, or by pair and immediate loads unless a skipping op skipped them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            skip_r <= 1'b0;
            load_chain_r <= 1'b0;
            last_kind_r <= CTAI_K_NONE;
        end else if (instr_valid && !tab_phase_r) begin
            skip_r <= 1'b0;
            load_chain_r <= 1'b0;
            if (skip_now) begin
                // A chain of equal loads keeps skipping while it lasts.
                if (load_chain_r) begin
                    skip_r <= 1'b1;
                    load_chain_r <= 1'b1;
                end
            end else begin
                case (kind)
                    CTAI_K_INC, CTAI_K_XCHI:
                        skip_r <= (digit_up == CTAI_DIGIT_WRAP_UP);
                    CTAI_K_DEC, CTAI_K_XCHD:
                        skip_r <= (digit_dn == CTAI_DIGIT_WRAP_DN);
                    CTAI_K_PAIR, CTAI_K_LDA: begin
                        skip_r <= 1'b1;
                        load_chain_r <= 1'b1;
                    end
                    default:
                        skip_r <= 1'b0;
                endcase
            end
            last_kind_r <= kind;
        end
    end

    // ==========================================================
    // Accumulator, upper nibble and carry
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_r <= 4'h0;
            upper_r <= 4'h0;
            carry_flag_r <= 1'b0;
        end else if (tab_phase_r) begin
            upper_r <= rom_rdata[7:4];
            acc_r <= rom_rdata[3:0];
        end else if (exec) begin
            case (kind)
                CTAI_K_BANK_A:
                    acc_r[1:0] <= data_pointer_r.bank;
                CTAI_K_FILE_A:
                    acc_r <= data_pointer_r.file;
                CTAI_K_STACK_A:
                    acc_r[2:0] <= stack_pointer_r;
                CTAI_K_M2A, CTAI_K_XCH, CTAI_K_XCHD, CTAI_K_XCHI:
                    acc_r <= ram_rdata;
                CTAI_K_LDA:
                    acc_r <= instr_word[3:0];
                CTAI_K_ADD: begin
                    acc_r <= sum[3:0];
                    if (with_carry) begin
                        carry_flag_r <= sum[4];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Data pointer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_pointer_r <= '0;
        end else if (exec) begin
            case (kind)
                CTAI_K_PAIR: begin
                    data_pointer_r.file <= instr_word[7:4];
                    data_pointer_r.digit <= instr_word[3:0];
                end
                CTAI_K_BANK_LD:
                    data_pointer_r.bank <= instr_word[1:0];
                CTAI_K_INC:
                    data_pointer_r.digit <= digit_up;
                CTAI_K_DEC:
                    data_pointer_r.digit <= digit_dn;
                CTAI_K_M2A, CTAI_K_XCH, CTAI_K_A2M:
                    data_pointer_r.file <= data_pointer_r.file ^
                        instr_word[3:0];
                CTAI_K_XCHD: begin
                    data_pointer_r.file <= data_pointer_r.file ^
                        instr_word[3:0];
                    data_pointer_r.digit <= digit_dn;
                end
                CTAI_K_XCHI: begin
                    data_pointer_r.file <= data_pointer_r.file ^
                        instr_word[3:0];
                    data_pointer_r.digit <= digit_up;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // RAM write: exchange and store use the old accumulator value
    always_comb begin
        ram_we = 1'b0;
        ram_wdata = acc_r;
        if (exec) begin
            case (kind)
                CTAI_K_XCH, CTAI_K_XCHD, CTAI_K_XCHI, CTAI_K_A2M:
                    ram_we = 1'b1;
                default:
                    ram_we = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Table reference: push, fetch, pop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tab_phase_r <= 1'b0;
            tab_addr_r <= '0;
            stack_pointer_r <= '1;
            return_stack_r <= '0;
        end else if (tab_phase_r) begin
            tab_phase_r <= 1'b0;
            stack_pointer_r <= stack_pointer_r - 1'b1;
        end else if (exec && kind == CTAI_K_TAB) begin
            tab_phase_r <= 1'b1;
            stack_pointer_r <= stack_pointer_r + 1'b1;
            return_stack_r <= {{(PAGE_BITS){1'b0}}, pc_in};
            tab_addr_r <= {instr_word[PAGE_BITS-1:0],
                table_high_bits, acc_r};
        end
    end

    // The fetch sequencer reloads the saved counter when the pop occurs.
    assign pc_load = tab_phase_r;
    assign pc_load_value = return_stack_r;
endmodule

// ### sim/ctai_core_asserts.sv
// Purpose: Concurrent checks on the instruction core's register results.
// Assumes: One clock domain; only the core's ports are watched.
// Notes: Skipped words are judged by the bench, not here.
`timescale 1ns/1ps
module ctai_core_asserts
    import ctai_pkg::*;
#(
    parameter int PAGE_BITS = 5,
    parameter int STACK_BITS = 3
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic instr_ready,
    input wire logic [3:0] acc_r,
    input wire logic carry_flag_r,
    input wire ctai_dptr_s data_pointer_r,
    input wire logic [STACK_BITS-1:0] stack_pointer_r,
    input wire logic skip_r,
    input wire logic [3:0] ram_rdata,
    input wire logic ram_we,
    input wire logic [3:0] ram_wdata
);
    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic take;
    logic [5:0] op6;
    assign take = instr_valid && instr_ready && !skip_r;
    assign op6 = instr_word[9:4];
    chk_lda_value: assert property (
        take && op6 == CTAI_PFX_LDA |=> acc_r == $past(instr_word[3:0]))
        else $error("immediate load wrong");
    chk_bank_to_acc: assert property (
        take && instr_word == CTAI_OP_BANK_TO_ACC
        |=> acc_r[1:0] == $past(data_pointer_r.bank)) else $error("bank copy");
    chk_stack_to_acc: assert property (
        take && instr_word == CTAI_OP_STACK_TO_ACC
        |=> acc_r[2:0] == $past(stack_pointer_r)) else $error("stack copy");
    chk_pair_load: assert property (
        take && instr_word[9:8] == CTAI_PFX_PAIR
        |=> data_pointer_r[7:0] == $past(instr_word[7:0])) else $error("pair");
    chk_inc_skip: assert property (
        take && instr_word == CTAI_OP_INC_DIGIT
        |=> data_pointer_r.digit == $past(data_pointer_r.digit) + 4'h1
        && skip_r == (data_pointer_r.digit == 4'h0)) else $error("inc skip");
    chk_dec_skip: assert property (
        take && instr_word == CTAI_OP_DEC_DIGIT
        |=> data_pointer_r.digit == $past(data_pointer_r.digit) - 4'h1
        && skip_r == (data_pointer_r.digit == 4'hf)) else $error("dec skip");
    chk_add_plain: assert property (
        take && instr_word == CTAI_OP_MEM_ADD
        |=> acc_r == $past(acc_r) + $past(ram_rdata) && $stable(carry_flag_r))
        else $error("plain add");
    chk_add_carry: assert property (
        take && instr_word == CTAI_OP_MEM_ADDC |=> {carry_flag_r, acc_r} ==
        $past(acc_r) + $past(ram_rdata) + $past(carry_flag_r))
        else $error("add with carry");
    chk_store_acc: assert property (
        take && op6 == CTAI_PFX_A2M |-> ram_we && ram_wdata == acc_r)
        else $error("store");
    cover property (take && instr_word == CTAI_OP_INC_DIGIT ##1 skip_r);
    cover property (take && instr_word == CTAI_OP_MEM_ADDC ##1 carry_flag_r);
    cover property (!instr_ready ##1 instr_ready);
endmodule
bind ctai_core ctai_core_asserts #(.PAGE_BITS(PAGE_BITS),
    .STACK_BITS(STACK_BITS)) u_chk (.*);

// ### sim/cpu_transfer_add_instructions_tb.sv
// Purpose: Directed bench for the transfer, pointer, table and add core.
// Assumes: RAM and ROM modelled here, answering combinationally.
// Notes: Each task drives a short program and judges the registers.
`timescale 1ns/1ps
module cpu_transfer_add_instructions_tb;
    import ctai_pkg::*;
    logic ref_clk = 1'h0, reset = 1'h1, instr_valid = 1'h0;
    logic [9:0] instr_word = 10'h000, rom_rdata;
    logic [6:0] pc_in = 7'h21;
    logic [2:0] table_high_bits = 3'h3, stack_pointer_r;
    logic instr_ready, carry_flag_r, skip_r, ram_we, pc_load;
    logic [3:0] acc_r, upper_r, ram_rdata, ram_wdata, last_wd;
    logic [11:0] return_stack_r, rom_addr, pc_load_value;
    logic [7:0] ram_addr;
    logic [3:0] mem [256];
    ctai_dptr_s data_pointer_r;
    int fails = 0, compares = 0;
    // ==========================================================
    // Memories and design
    assign ram_rdata = mem[ram_addr];
    // Only the expected table address answers with the marked word.
    assign rom_rdata = (rom_addr === 12'h9b5) ? 10'h3a7 : 10'h0c3;
    always @(posedge ref_clk) if (ram_we) begin
        mem[ram_addr] <= ram_wdata;
        last_wd <= ram_wdata;
    end
    ctai_core DUT (.*);
    initial forever #50 ref_clk = ~ref_clk;
    // ==========================================================
    // Helpers
    task chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Valid stays high between words so it never toggles twice at once.
    task issue(input logic [9:0] w);
        logic ok;
        instr_word = w;
        instr_valid = 1'h1;
        do begin
            ok = (instr_ready === 1'h1);
            @(posedge ref_clk);
            #1;
        end while (!ok);
    endtask
    task idle;
        instr_valid = 1'h0;
        @(posedge ref_clk);
        #1;
    endtask
    task fill(input logic [3:0] v);
        foreach (mem[i]) mem[i] = v;
    endtask
    // ==========================================================
    // Scenarios
    task t_pointers;
        issue({CTAI_PFX_BANK, 2'h2});
        chk(data_pointer_r.bank, 12'h2);
        issue({CTAI_PFX_PAIR, 8'h53});
        issue({CTAI_PFX_PAIR, 8'h9e});
        chk(data_pointer_r[7:0], 12'h53);
        issue(CTAI_OP_FILE_TO_ACC);
        chk({data_pointer_r.file, acc_r}, 12'h55);
        issue(CTAI_OP_BANK_TO_ACC);
        chk(acc_r[1:0], 12'h2);
        issue(CTAI_OP_STACK_TO_ACC);
        chk(acc_r[2:0], 12'h7);
    endtask
    task t_lda;
        issue({CTAI_PFX_LDA, 4'h3});
        issue({CTAI_PFX_LDA, 4'hc});
        issue({CTAI_PFX_LDA, 4'h9});
        chk(acc_r, 12'h3);
        issue(CTAI_OP_FILE_TO_ACC);
        chk(acc_r, 12'h5);
        issue({CTAI_PFX_LDA, 4'hf});
        chk(acc_r, 12'hf);
    endtask
    task t_digit;
        issue({CTAI_PFX_PAIR, 8'h5f});
        issue(CTAI_OP_INC_DIGIT);
        chk({skip_r, data_pointer_r.digit}, 12'h10);
        issue({CTAI_PFX_LDA, 4'h1});
        chk(acc_r, 12'hf);
        issue(CTAI_OP_DEC_DIGIT);
        chk({skip_r, data_pointer_r.digit}, 12'h1f);
        issue(CTAI_OP_INC_DIGIT);
        chk(data_pointer_r.digit, 12'hf);
        issue(CTAI_OP_DEC_DIGIT);
        chk({skip_r, data_pointer_r.digit}, 12'h0e);
        issue(CTAI_OP_INC_DIGIT);
        chk({skip_r, data_pointer_r.digit}, 12'h0f);
    endtask
    task t_memory;
        fill(4'h6);
        issue({CTAI_PFX_XCH, 4'h5});
        chk({acc_r, last_wd, data_pointer_r.file}, 12'h6f0);
        issue({CTAI_PFX_A2M, 4'ha});
        chk({acc_r, last_wd, data_pointer_r.file}, 12'h66a);
        fill(4'h2);
        issue({CTAI_PFX_M2A, 4'h3});
        chk({acc_r, data_pointer_r.file}, 12'h29);
        fill(4'hb);
        issue({CTAI_PFX_XCHI, 4'h1});
        chk({acc_r, last_wd, data_pointer_r.file}, 12'hb28);
        chk(skip_r, 12'h1);
        chk(data_pointer_r.digit, 12'h0);
        issue(CTAI_OP_MEM_ADD);
        chk({skip_r, acc_r}, 12'h0b);
        fill(4'h8);
        issue({CTAI_PFX_XCHD, 4'h0});
        chk({acc_r, last_wd, data_pointer_r.digit}, 12'h8bf);
        chk(skip_r, 12'h1);
        issue(CTAI_OP_MEM_ADD);
        chk({skip_r, acc_r}, 12'h08);
    endtask
    task t_add;
        fill(4'h9);
        issue({CTAI_PFX_LDA, 4'h8});
        issue(CTAI_OP_MEM_ADD);
        chk({carry_flag_r, acc_r}, 12'h01);
        issue(CTAI_OP_MEM_ADDC);
        chk({carry_flag_r, acc_r}, 12'h0a);
        issue({CTAI_PFX_LDA, 4'h7});
        issue(CTAI_OP_MEM_ADDC);
        chk({carry_flag_r, acc_r}, 12'h10);
        issue(CTAI_OP_MEM_ADD);
        chk({carry_flag_r, acc_r}, 12'h19);
        issue(CTAI_OP_MEM_ADDC);
        chk({carry_flag_r, acc_r}, 12'h13);
    endtask
    task t_table;
        issue({CTAI_PFX_LDA, 4'h5});
        issue({CTAI_PFX_TAB, 5'h13});
        chk({instr_ready, pc_load, stack_pointer_r}, 12'h08);
        chk(pc_load_value, 12'h021);
        idle();
        chk({instr_ready, stack_pointer_r, upper_r, acc_r}, 12'hfa7);
    endtask
    // ==========================================================
    // Run control
    task report_and_stop;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        reset = 1'h0;
        t_pointers();
        t_lda();
        t_digit();
        t_memory();
        t_add();
        t_table();
        report_and_stop();
    end
endmodule
